// >>> logic/uit_map.svh
// How it works
// - Device code 54 octal; interrupt mask bit 4 gates the interrupt request.
// - Start pulse sets busy, clears done, arming one overflow interrupt.
// - Armed overflow clears busy, sets done, requests interrupt unless masked or inhibited by bus I/O reset.
// - Clear pulse clears busy and done; no more timer interrupts until rearmed.
// - Sample, direct load and zero act only on the auxiliary pulse.
// - Bus I/O reset inhibits timer interrupts, control bits untouched.
// - Bus I/O reset leaves a running counter counting; it may still wrap.
// - Every wrap disables target reply cards until beacon interrogation or bus reset.
// - Auxiliary pulse with sample select 1 copies counter into sample register.
// - Data-in-A returns sample when sample select 1, else preset.
// - Data-out-A write loads the preset register.
// - Data-in-C returns current control and status bits.
// - External load enable loads counter from preset on each external load without a same-cycle auxiliary pulse.
// - Reload on wrap loads counter from preset at each overflow without a same-cycle auxiliary pulse.
// - Stop on overflow halts counting at overflow.
// - Run/halt bit: 0 counts, 1 holds the counter stopped.
`ifndef UIT_MAP_SVH
`define UIT_MAP_SVH
`define UIT_OFF_PRESET 8'h00
`define UIT_OFF_CTRL 8'h04
`define UIT_OFF_CMD 8'h08
`define UIT_OFF_COUNT 8'h0c
`define UIT_OFF_MASK 8'h10
`define UIT_OFF_ID 8'h14
`define UIT_B_EXT 0
`define UIT_B_RELOAD 1
`define UIT_B_STOPW 2
`define UIT_B_SEL 3
`define UIT_B_LOAD 4
`define UIT_B_ZERO 5
`define UIT_B_RUNH 6
`define UIT_B_BUSY 7
`define UIT_B_DONE 8
`define UIT_B_START 0
`define UIT_B_CLEAR 1
`define UIT_B_AUX 2
`define UIT_B_BUS_IO_RESET 3
`define UIT_MASK_BIT 4
`define UIT_CTRL_RST 7'h00
`define UIT_DEV_CODE 6'h2c
`define UIT_RESP_OK 2'h0
`define UIT_RESP_ERR 2'h2
`endif

// >>> logic/uit_pkg.sv
package uit_pkg;
   typedef logic [1:0] uit_resp_t;
   typedef logic [6:0] uit_ctrl_t;
   typedef logic [7:0] uit_addr_t;
   typedef logic [31:0] uit_word_t;
endpackage

// >>> logic/uit_timer.sv
`timescale 1ns/1ps
`include "uit_map.svh"
module uit_timer #(
   parameter int CNT_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic timer_tick,
   input wire logic ext_load,
   input wire logic beacon_interrogation,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire uit_pkg::uit_addr_t s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire uit_pkg::uit_word_t s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output uit_pkg::uit_resp_t s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire uit_pkg::uit_addr_t s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output uit_pkg::uit_word_t s_axi_rdata,
   output uit_pkg::uit_resp_t s_axi_rresp,
   output logic int_req,
   output logic reply_disable
);
   import uit_pkg::*;

   // Byte-lane merge of a write into an old word
   function automatic uit_word_t merge(input uit_word_t old, input uit_word_t nw,
                                       input logic [3:0] be);
      uit_word_t m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return m;
   endfunction

   function automatic logic mapped(input uit_addr_t a);
      return a == `UIT_OFF_PRESET || a == `UIT_OFF_CTRL || a == `UIT_OFF_CMD ||
             a == `UIT_OFF_COUNT || a == `UIT_OFF_MASK || a == `UIT_OFF_ID;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Bus handshake state
   logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
   uit_addr_t awaddr_r, awaddr_nxt;
   uit_word_t wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
   uit_resp_t bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   uit_word_t rdata_r, rdata_nxt, rd_word;
   logic wr_go, ar_fire;

   // Timer state
   logic [CNT_W-1:0] cnt_r, cnt_nxt, preset_r, preset_nxt, sample_r, sample_nxt;
   uit_ctrl_t ctrl_r, ctrl_nxt;
   logic busy_r, busy_nxt, done_r, done_nxt, inhibit_r, inhibit_nxt;
   logic [15:0] mask_r, mask_nxt;
   logic int_r, int_nxt, rdis_r, rdis_nxt;
   logic wr_preset, wr_ctrl, wr_cmd, wr_mask;
   logic cmd_start, cmd_clear, cmd_aux, cmd_bus_io_reset, running, ovf;
   uit_word_t cmd_word, ctrl_word;

   assign wr_go = aw_have_r && w_have_r && !bvalid_r;
   assign ar_fire = s_axi_arvalid && arready_r;

   always_comb begin
      aw_have_nxt = aw_have_r;
      awaddr_nxt = awaddr_r;
      w_have_nxt = w_have_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      arready_nxt = arready_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_axi_awvalid && !aw_have_r) begin
         aw_have_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_r) begin
         w_have_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      if (wr_go) begin
         aw_have_nxt = 1'b0;
         w_have_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = mapped(awaddr_r) ? `UIT_RESP_OK : `UIT_RESP_ERR;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (ar_fire) begin
         arready_nxt = 1'b0;
         rvalid_nxt = 1'b1;
         rdata_nxt = rd_word;
         rresp_nxt = mapped(s_axi_araddr) ? `UIT_RESP_OK : `UIT_RESP_ERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
         arready_nxt = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         awaddr_r <= '0;
         w_have_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
         bvalid_r <= 1'b0;
         bresp_r <= `UIT_RESP_OK;
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= `UIT_RESP_OK;
      end else if (ce) begin
         aw_have_r <= aw_have_nxt;
         awaddr_r <= awaddr_nxt;
         w_have_r <= w_have_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // Ready is simply "slot empty", so both stay flop outputs
   assign s_axi_awready = !aw_have_r;
   assign s_axi_wready = !w_have_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Register decode and read mux
   assign wr_preset = wr_go && awaddr_r == `UIT_OFF_PRESET;
   assign wr_ctrl = wr_go && awaddr_r == `UIT_OFF_CTRL;
   assign wr_cmd = wr_go && awaddr_r == `UIT_OFF_CMD;
   assign wr_mask = wr_go && awaddr_r == `UIT_OFF_MASK;
   assign cmd_word = merge('0, wdata_r, wstrb_r);
   assign cmd_start = wr_cmd && cmd_word[`UIT_B_START];
   assign cmd_clear = wr_cmd && cmd_word[`UIT_B_CLEAR];
   assign cmd_aux = wr_cmd && cmd_word[`UIT_B_AUX];
   assign cmd_bus_io_reset = wr_cmd && cmd_word[`UIT_B_BUS_IO_RESET];
   assign ctrl_word = {23'h000000, done_r, busy_r, ctrl_r};
   assign running = !ctrl_r[`UIT_B_RUNH];
   assign ovf = running && timer_tick && (&cnt_r);

   always_comb begin
      rd_word = '0;
      case (s_axi_araddr)
         `UIT_OFF_PRESET: rd_word[CNT_W-1:0] = ctrl_r[`UIT_B_SEL] ? sample_r : preset_r;
         `UIT_OFF_CTRL: rd_word = ctrl_word;
         `UIT_OFF_COUNT: rd_word[CNT_W-1:0] = cnt_r;
         `UIT_OFF_MASK: rd_word[15:0] = mask_r;
         `UIT_OFF_ID: rd_word[5:0] = `UIT_DEV_CODE;
         default: rd_word = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Timer core
   always_comb begin
      uit_word_t tmp;
      tmp = '0;
      preset_nxt = preset_r;
      ctrl_nxt = ctrl_r;
      sample_nxt = sample_r;
      cnt_nxt = cnt_r;
      busy_nxt = busy_r;
      done_nxt = done_r;
      inhibit_nxt = inhibit_r;
      mask_nxt = mask_r;
      rdis_nxt = rdis_r;
      if (wr_preset) begin
         tmp = merge({{(32-CNT_W){1'b0}}, preset_r}, wdata_r, wstrb_r);
         preset_nxt = tmp[CNT_W-1:0];
      end
      if (wr_ctrl) begin
         tmp = merge(ctrl_word, wdata_r, wstrb_r);
         ctrl_nxt = tmp[6:0]; // Writing bits alone starts nothing
      end
      if (wr_mask) begin
         tmp = merge({16'h0000, mask_r}, wdata_r, wstrb_r);
         mask_nxt = tmp[15:0];
      end
      // Counter: aux actions, then external load, then counting
      if (cmd_aux) begin
         if (ctrl_r[`UIT_B_SEL]) begin
            sample_nxt = cnt_r;
         end else if (ctrl_r[`UIT_B_ZERO]) begin
            cnt_nxt = '0;
         end else if (ctrl_r[`UIT_B_LOAD]) begin
            cnt_nxt = preset_r;
         end
      end else if (ctrl_r[`UIT_B_EXT] && ext_load) begin
         cnt_nxt = preset_r;
      end else if (ovf) begin
         cnt_nxt = ctrl_r[`UIT_B_RELOAD] ? preset_r : '0;
      end else if (running && timer_tick) begin
         cnt_nxt = cnt_r + 1'b1;
      end
      if (ovf && ctrl_r[`UIT_B_STOPW]) begin // Beats a same-cycle control write
         ctrl_nxt[`UIT_B_RUNH] = 1'b1;
      end
      // Busy/done: clear first, then start, overflow set wins last
      if (cmd_clear) begin
         busy_nxt = 1'b0;
         done_nxt = 1'b0;
      end
      if (cmd_start) begin
         busy_nxt = 1'b1;
         done_nxt = 1'b0;
         inhibit_nxt = 1'b0;
      end
      if (ovf && busy_r) begin
         busy_nxt = 1'b0;
         done_nxt = 1'b1;
      end
      if (cmd_bus_io_reset) begin
         inhibit_nxt = 1'b1;
      end
      // Reply cards: wrap set beats beacon or reset clear
      if (beacon_interrogation || cmd_bus_io_reset) begin
         rdis_nxt = 1'b0;
      end
      if (ovf) begin
         rdis_nxt = 1'b1;
      end
      int_nxt = done_nxt && !inhibit_nxt && !mask_nxt[`UIT_MASK_BIT];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         preset_r <= '0;
         ctrl_r <= `UIT_CTRL_RST;
         sample_r <= '0;
         cnt_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         inhibit_r <= 1'b0;
         mask_r <= '0;
         int_r <= 1'b0;
         rdis_r <= 1'b0;
      end else if (ce) begin
         preset_r <= preset_nxt;
         ctrl_r <= ctrl_nxt;
         sample_r <= sample_nxt;
         cnt_r <= cnt_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         inhibit_r <= inhibit_nxt;
         mask_r <= mask_nxt;
         int_r <= int_nxt;
         rdis_r <= rdis_nxt;
      end
   end

   assign int_req = int_r;
   assign reply_disable = rdis_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_start;
      ce && cmd_start && !(ovf && busy_r) |=> busy_r && !done_r;
   endproperty
   a_start: assert property (p_start) else $error("start did not arm");
   property p_ovf_done;
      ce && ovf && busy_r |=> done_r && !busy_r;
   endproperty
   a_ovf_done: assert property (p_ovf_done) else $error("overflow did not finish");
   property p_clear;
      ce && cmd_clear && !cmd_start && !(ovf && busy_r) |=> !busy_r && !done_r && !int_req;
   endproperty
   a_clear: assert property (p_clear) else $error("clear left flags");
   property p_bus_io_reset;
      ce && cmd_bus_io_reset && !ovf |=> !int_req && ctrl_r == $past(ctrl_r);
   endproperty
   a_bus_io_reset: assert property (p_bus_io_reset) else $error("reset pulse misbehaved");
   property p_keep_count;
      ce && cmd_bus_io_reset && running && timer_tick && !ovf && !cmd_aux
         && !(ctrl_r[`UIT_B_EXT] && ext_load) |=> cnt_r == $past(cnt_r) + 1'b1;
   endproperty
   a_keep_count: assert property (p_keep_count) else $error("count stopped");
   property p_reply;
      ce && ovf |=> reply_disable;
   endproperty
   a_reply: assert property (p_reply) else $error("reply cards not disabled");
   property p_sample;
      ce && cmd_aux && ctrl_r[`UIT_B_SEL] |=> sample_r == $past(cnt_r);
   endproperty
   a_sample: assert property (p_sample) else $error("sample not taken");
   property p_read_a;
      ce && ar_fire && s_axi_araddr == `UIT_OFF_PRESET |=>
         rdata_r[CNT_W-1:0] == ($past(ctrl_r[`UIT_B_SEL]) ? $past(sample_r) : $past(preset_r));
   endproperty
   a_read_a: assert property (p_read_a) else $error("data-in-A wrong");
   property p_reload;
      ce && ovf && !cmd_aux && !(ctrl_r[`UIT_B_EXT] && ext_load) |=>
         cnt_r == ($past(ctrl_r[`UIT_B_RELOAD]) ? $past(preset_r) : '0);
   endproperty
   a_reload: assert property (p_reload) else $error("wrap load wrong");
   property p_stop;
      ce && ovf && ctrl_r[`UIT_B_STOPW] |=> ctrl_r[`UIT_B_RUNH];
   endproperty
   a_stop: assert property (p_stop) else $error("no stop on wrap");
   property p_halted;
      ce && !running && !cmd_aux && !ext_load && !wr_ctrl |=> cnt_r == $past(cnt_r);
   endproperty
   a_halted: assert property (p_halted) else $error("halted counter moved");
   c_wrap_int: cover property (busy_r && ovf ##1 int_req);
   c_sample: cover property (cmd_aux && ctrl_r[`UIT_B_SEL]);
   c_beacon: cover property (reply_disable ##1 !reply_disable);
endmodule // uit_timer

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`include "uit_map.svh"
module tb_top;
   import uit_pkg::*;
   localparam int W = 4;
   localparam uit_addr_t PR = `UIT_OFF_PRESET;
   localparam uit_addr_t CT = `UIT_OFF_CTRL;
   localparam uit_addr_t CM = `UIT_OFF_CMD;
   localparam uit_addr_t CN = `UIT_OFF_COUNT;
   localparam uit_addr_t MK = `UIT_OFF_MASK;
   logic aclk, aresetn, tick, ext_load, ping, beacon, card_ready, int_req, reply_disable;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   uit_addr_t awaddr, araddr;
   uit_word_t wdata, rdata, rv;
   uit_resp_t bresp, rresp, rs;
   logic ce;
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;
   ////////////////////////////////////////
   // Small counter width so a wrap takes 16 ticks
   uit_timer #(.CNT_W(W)) DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .timer_tick(tick),
      .ext_load(ext_load), .beacon_interrogation(beacon), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .int_req(int_req), .reply_disable(reply_disable));
   uit_card_model CARD (.aclk(aclk), .reply_disable(reply_disable), .ping(ping),
      .beacon_interrogation(beacon), .card_ready(card_ready));
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   ////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Whole run needs under 2000 cycles
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end
   task automatic chk(input string nm, input uit_word_t seen, input uit_word_t exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input uit_addr_t a, input uit_word_t d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      rs = bresp;
      // Let an edge pass so the next call never drives twice in one step
      @(posedge aclk);
   endtask
   task automatic rd(input uit_addr_t a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      rv = rdata;
      rs = rresp;
      @(posedge aclk);
   endtask
   task automatic ex(input string nm, input uit_addr_t a, input uit_word_t e);
      rd(a);
      chk(nm, rv, e);
   endtask
   task automatic ticks(input int n);
      tick <= 1'b1;
      repeat (n) @(posedge aclk);
      tick <= 1'b0;
   endtask
   // Zero through the aux pulse, then leave control clear
   task automatic zero();
      wr(CT, 32'h00000020);
      wr(CM, 32'h00000004);
      wr(CT, 32'h00000000);
   endtask
   ////////////////////////////////////////
   initial begin
      aresetn = 1'b0; tick = 1'b0; ext_load = 1'b0; ping = 1'b0; awvalid = 1'b0;
      wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      awaddr = 8'h00; araddr = 8'h00; wdata = 32'h00000000;
      ce = 1'b1;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      ex("ctrl_reset", CT, 32'h00000000);
      rd(`UIT_OFF_ID);
      chk("dev_code", rv & 32'h0000003f, 32'h0000002c);
      chk("rresp_ok", rs, `UIT_RESP_OK);
      rd(8'h40);
      chk("unmapped_resp", rs, `UIT_RESP_ERR);
      chk("unmapped_data", rv, 32'h00000000);
      wr(8'h40, 32'h00000001);
      chk("unmapped_wresp", rs, `UIT_RESP_ERR);
      wr(PR, 32'h00000005);
      chk("wresp_ok", rs, `UIT_RESP_OK);
      ex("preset", PR, 32'h00000005);
      wr(CT, 32'h00000047);
      ex("ctrl_rdback", CT, 32'h00000047);
      $display("test registers done");
      wr(CT, 32'h00000010);
      ex("no_load_yet", CN, 32'h00000000);
      wr(CM, 32'h00000004);
      ex("direct_load", CN, 32'h00000005);
      zero();
      ex("zeroed", CN, 32'h00000000);
      wr(CT, 32'h00000040);
      ticks(3);
      ex("halted", CN, 32'h00000000);
      wr(CT, 32'h00000000);
      ticks(3);
      ex("counting", CN, 32'h00000003);
      // Clock enable low must freeze the count even with ticks present
      ce <= 1'b0;
      ticks(3);
      ce <= 1'b1;
      ex("frozen", CN, 32'h00000003);
      wr(CT, 32'h00000008);
      wr(CM, 32'h00000004);
      ticks(2);
      ex("sample", PR, 32'h00000003);
      ex("live", CN, 32'h00000005);
      wr(CT, 32'h00000000);
      ex("preset_sel0", PR, 32'h00000005);
      $display("test counter done");
      wr(MK, 32'h00000000);
      zero();
      wr(CM, 32'h00000001);
      ex("armed", CT, 32'h00000080);
      ticks(15);
      ex("before_wrap", CT, 32'h00000080);
      ticks(1);
      ex("done", CT, 32'h00000100);
      chk("int_req_on", int_req, 1'b1);
      chk("reply_off", reply_disable, 1'b1);
      chk("card_ready", card_ready, 1'b0);
      ping <= 1'b1;
      @(posedge aclk);
      ping <= 1'b0;
      repeat (3) @(posedge aclk);
      chk("beacon_clears", reply_disable, 1'b0);
      wr(CM, 32'h00000002);
      ex("cleared", CT, 32'h00000000);
      ticks(16);
      rd(CT);
      chk("no_rearm", int_req, 1'b0);
      chk("reply_again", reply_disable, 1'b1);
      wr(CM, 32'h00000008);
      rd(CT);
      chk("bus_io_reset_clears_reply", reply_disable, 1'b0);
      $display("test interrupt done");
      wr(MK, 32'h00000010);
      wr(CM, 32'h00000001);
      ticks(16);
      ex("masked_done", CT, 32'h00000100);
      chk("masked_irq", int_req, 1'b0);
      wr(MK, 32'h00000000);
      rd(CT);
      chk("unmasked_irq", int_req, 1'b1);
      wr(CM, 32'h00000002);
      wr(CT, 32'h00000001);
      wr(CM, 32'h00000001);
      // Tick through the reset pulse so the count must carry on
      tick <= 1'b1;
      wr(CM, 32'h00000008);
      tick <= 1'b0;
      ex("bus_io_reset_ctrl", CT, 32'h00000081);
      ex("count_thru_bus_io_reset", CN, 32'h00000004);
      ticks(16);
      ex("runs_on", CT, 32'h00000101);
      chk("inhibited", int_req, 1'b0);
      wr(CM, 32'h00000002);
      $display("test masking done");
      zero();
      wr(CT, 32'h00000002);
      ticks(16);
      ex("reload", CN, 32'h00000005);
      wr(CT, 32'h00000004);
      ticks(11);
      ex("stop_bit", CT, 32'h00000044);
      ticks(2);
      ex("stopped", CN, 32'h00000000);
      wr(CT, 32'h00000001);
      ext_load <= 1'b1;
      @(posedge aclk);
      ext_load <= 1'b0;
      ex("ext_load", CN, 32'h00000005);
      wr(CT, 32'h00000000);
      wr(PR, 32'h00000009);
      ext_load <= 1'b1;
      @(posedge aclk);
      ext_load <= 1'b0;
      ex("ext_off", CN, 32'h00000005);
      $display("test loads done");
      complete_run();
   end
endmodule // tb_top

// >>> sim/uit_card_model.sv
`timescale 1ns/1ps
// Target reply card: stops replying after a wrap until a beacon ping or bus I/O reset
module uit_card_model (
   input wire logic aclk,
   input wire logic reply_disable,
   input wire logic ping,
   output logic beacon_interrogation,
   output logic card_ready
);
   always_ff @(posedge aclk) begin
      beacon_interrogation <= ping;
      card_ready <= !reply_disable;
   end
endmodule // uit_card_model
